/* File: rtl/bac_top.v */
// Purpose: Conversion control and ready/data output of a bridge converter
// Assumes: I_REF_CLK is the master clock; Wishbone classic slave
// Notes:   Pins pass a three-stage synchroniser before use
//
// Functional notes
// - The modulator stream is decimated by a sinc4 filter repeating at 76.8 kHz.
// - The filter corner is 2.4 Hz at the slow rate and 19 Hz at the fast rate.
// - At the slow rate the filter nulls fall on every multiple of 10 Hz.
// - Rate select low gives 10 results per second and high gives 80.
// - Result rate is master clock over 491,520 slow or 61,440 fast.
// - Rate scales with the clock only when an external clock is used.
// - A channel select toggle drives the line high until settled data exist.
// - Each result is a 24-bit two's complement value.
// - Results clip at 7FFFFF and 800000 beyond full scale.
// - Zero input gives zero, one step either side gives plus or minus one.
// - A new result is signalled by driving the line low.
// - The first shift clock rise gives the MSB, each later rise the next bit.
// - One shift clock after 24 bits forces the line high until new data.
// - Conversion runs continuously with no start command.
`timescale 1ns/1ns
`default_nettype none
`include "bac_defs.vh"

module bac_top
#(
  parameter [6:0]  MOD_DIV  = `BAC_MOD_DIV,
  parameter [12:0] DEC_SLOW = `BAC_DEC_SLOW,
  parameter [12:0] DEC_FAST = `BAC_DEC_FAST,
  parameter        ACC_W    = 56
)
(
  input  wire        I_REF_CLK,
  input  wire        I_RST_N,
  input  wire        I_MOD_BIT,
  input  wire        I_SPEED,
  input  wire        I_CHANNEL_SELECT_BIT0,
  input  wire        I_CHANNEL_SELECT_BIT1,
  input  wire        I_SCLK,
  output reg         O_READY_DATA_LINE,
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [7:0]  I_WB_ADR,
  input  wire [3:0]  I_WB_SEL,
  input  wire [31:0] I_WB_DAT,
  output reg  [31:0] O_WB_DAT,
  output reg         O_WB_ACK
);

  // ----------------------------------------------------------------
  // Output state machine codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_READY = 3'h2;
  localparam [2:0] ST_SHIFT = 3'h4;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [4:0] pin_raw = {I_SCLK, I_CHANNEL_SELECT_BIT1, I_CHANNEL_SELECT_BIT0,
                        I_SPEED, I_MOD_BIT};
  reg  [4:0] sync1;
  reg  [4:0] sync2;
  reg  [4:0] sync3;
  reg  [4:0] pin;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_sync
      always @(posedge I_REF_CLK or negedge I_RST_N)
      begin
        if (!I_RST_N)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin[g]   <= 1'b0;
        end
        else
        begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          // Change accepted only when stages two and three agree
          if (sync2[g] == sync3[g])
            pin[g] <= sync3[g];
        end
      end
    end
  endgenerate

  wire       mod_bit  = pin[0];
  wire       spd_pin  = pin[1];
  wire [1:0] chan_sel = pin[3:2];
  wire       sclk     = pin[4];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [1:0]  ctrl;
  reg  [23:0] last_result;
  reg  [31:0] conv_count;

  // Software may override the rate pin
  wire fast = ctrl[`BAC_CTRL_OVR_BIT] ? ctrl[`BAC_CTRL_SPD_BIT] : spd_pin;

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  reg        sclk_d;
  reg  [1:0] chan_d;
  reg        fast_d;

  wire sclk_rise   = sclk & ~sclk_d;
  wire chan_toggle = (chan_sel != chan_d);
  // A rate change also restarts the filter, else one result is mixed
  wire restart     = chan_toggle | (fast != fast_d);

  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sclk_d <= 1'b0;
      chan_d <= 2'h0;
      fast_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk;
      chan_d <= chan_sel;
      fast_d <= fast;
    end
  end

  // ----------------------------------------------------------------
  // Modulator sample strobe
  // ----------------------------------------------------------------
  reg  [6:0] mod_cnt;
  wire       mod_stb = (mod_cnt == MOD_DIV - 7'h01);

  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      mod_cnt <= 7'h00;
    else
      mod_cnt <= mod_stb ? 7'h00 : mod_cnt + 7'h01;
  end

  // ----------------------------------------------------------------
  // Decimator
  // ----------------------------------------------------------------
  wire        dec_valid;
  wire [23:0] dec_data;

  wire [12:0] ratio = fast ? DEC_FAST : DEC_SLOW;
  wire [5:0]  shift = fast ? `BAC_SHIFT_FAST : `BAC_SHIFT_SLOW;

  bac_sinc4
  #(
    .ACC_W (ACC_W),
    .CNT_W (13)
  )
  u_sinc4
  (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_clear (restart),
    .i_stb   (mod_stb),
    .i_bit   (mod_bit),
    .i_ratio (ratio),
    .i_shift (shift),
    .o_valid (dec_valid),
    .o_data  (dec_data)
  );

  // ----------------------------------------------------------------
  // Settling and pending result
  // ----------------------------------------------------------------
  reg  [2:0]  drop_cnt;
  reg         pend_valid;
  reg  [23:0] pend_data;
  wire        settling = (drop_cnt != 3'h0);
  wire        buf_in_ready;
  wire        keep     = dec_valid & ~settling;

  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      drop_cnt    <= `BAC_SETTLE_DROP;
      pend_valid  <= 1'b0;
      pend_data   <= 24'h000000;
      last_result <= 24'h000000;
      conv_count  <= 32'h00000000;
    end
    else if (restart)
    begin
      drop_cnt   <= `BAC_SETTLE_DROP;
      pend_valid <= 1'b0;
    end
    else
    begin
      if (dec_valid && settling)
        drop_cnt <= drop_cnt - 3'h1;
      if (keep)
      begin
        pend_valid  <= 1'b1;
        pend_data   <= dec_data;
        last_result <= dec_data;
        conv_count  <= conv_count + 32'h00000001;
      end
      else if (buf_in_ready)
        pend_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry buffer
  // ----------------------------------------------------------------
  wire        buf_out_valid;
  wire [23:0] buf_out_data;
  reg  [2:0]  state;
  reg  [23:0] shreg;
  reg  [4:0]  sent;

  // Hold off while the host is mid-word, unless the buffer is full
  wire mid_word  = state[2] && (sent != `BAC_BITS_OUT);
  wire out_ready = ~mid_word | ~buf_in_ready;
  wire load      = buf_out_valid & out_ready;

  bac_fifo2
  #(
    .W     (24),
    .DEPTH (2),
    .AW    (1)
  )
  u_fifo
  (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_flush (restart),
    .i_valid (pend_valid),
    .o_ready (buf_in_ready),
    .i_data  (pend_data),
    .o_valid (buf_out_valid),
    .i_ready (out_ready),
    .o_data  (buf_out_data)
  );

  // ----------------------------------------------------------------
  // Ready/data line
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state             <= ST_IDLE;
      shreg             <= 24'h000000;
      sent              <= 5'h00;
      O_READY_DATA_LINE <= 1'b1;
    end
    else if (restart || settling)
    begin
      state             <= ST_IDLE;
      sent              <= 5'h00;
      O_READY_DATA_LINE <= 1'b1;
    end
    else if (load)
    begin
      state             <= ST_READY;
      shreg             <= buf_out_data;
      sent              <= 5'h00;
      O_READY_DATA_LINE <= 1'b0;
    end
    else if (sclk_rise)
    begin
      case (state)
        ST_READY:
        begin
          state             <= ST_SHIFT;
          O_READY_DATA_LINE <= shreg[23];
          shreg             <= {shreg[22:0], 1'b0};
          sent              <= 5'h01;
        end
        ST_SHIFT:
        begin
          if (sent == `BAC_BITS_OUT)
          begin
            state             <= ST_IDLE;
            O_READY_DATA_LINE <= 1'b1;
          end
          else
          begin
            O_READY_DATA_LINE <= shreg[23];
            shreg             <= {shreg[22:0], 1'b0};
            sent              <= sent + 5'h01;
          end
        end
        ST_IDLE:
        begin
          O_READY_DATA_LINE <= 1'b1;
        end
        default:
        begin
          state             <= ST_IDLE;
          O_READY_DATA_LINE <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  wire req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  reg  [31:0] rd_mux;

  always @*
  begin
    case (I_WB_ADR)
      `BAC_REG_CTRL:   rd_mux = {30'h00000000, ctrl};
      `BAC_REG_STATUS: rd_mux = {26'h0000000, buf_out_valid, state[2],
                                 fast, settling, O_READY_DATA_LINE,
                                 buf_in_ready};
      `BAC_REG_RESULT: rd_mux = {8'h00, last_result};
      `BAC_REG_COUNT:  rd_mux = conv_count;
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Unmapped offsets read zero and drop writes, but still acknowledge
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
      ctrl     <= `BAC_CTRL_RST;
    end
    else
    begin
      O_WB_ACK <= req;
      if (req && !I_WB_WE)
        O_WB_DAT <= rd_mux;
      if (req && I_WB_WE && I_WB_SEL[0] && (I_WB_ADR == `BAC_REG_CTRL))
        ctrl <= I_WB_DAT[1:0];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/bac_defs.vh */
// Purpose: Shared constants for the bridge converter conversion/output block
// Assumes: Included by bare name from every design file
// Notes:   Definitions only
`ifndef BAC_DEFS_VH
`define BAC_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte offsets, 32-bit words)
// ----------------------------------------------------------------
`define BAC_REG_CTRL      8'h00
`define BAC_REG_STATUS    8'h04
`define BAC_REG_RESULT    8'h08
`define BAC_REG_COUNT     8'h0C
`define BAC_CTRL_RST      2'h0
`define BAC_CTRL_OVR_BIT  0
`define BAC_CTRL_SPD_BIT  1

// ----------------------------------------------------------------
// Rates: modulator 76.8 kHz is master clock / 64
// ----------------------------------------------------------------
`define BAC_MOD_FREQ_HZ   17'h12C00
`define BAC_MOD_DIV       7'h40
// 491,520 / 64 = 7680 modulator samples per result
`define BAC_DEC_SLOW      13'h1E00
// 61,440 / 64 = 960 modulator samples per result
`define BAC_DEC_FAST      13'h03C0
`define BAC_SHIFT_SLOW    6'h28
`define BAC_SHIFT_FAST    6'h1C

// ----------------------------------------------------------------
// Settling and output coding
// ----------------------------------------------------------------
`define BAC_SETTLE_DROP   3'h3
`define BAC_POS_FS        24'h7FFFFF
`define BAC_NEG_FS        24'h800000
`define BAC_BITS_OUT      5'h18

`endif

/* File: rtl/bac_fifo2.v */
// Purpose: Small valid/ready buffer between decimator and serial output
// Assumes: DEPTH is a power of two
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ns
`default_nettype none
`include "bac_defs.vh"

module bac_fifo2
#(
  parameter W     = 24,
  parameter DEPTH = 2,
  parameter AW    = 1
)
(
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_flush,
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);

  localparam [AW:0] FULL = DEPTH;

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  assign o_ready = (count != FULL);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data  = mem[rd_ptr];

  always @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else if (i_flush)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* File: rtl/bac_sinc4.v */
// Purpose: Fourth-order sinc decimator with clipped 24-bit output
// Assumes: One modulator bit per i_stb; ratio stable between clears
// Notes:   Pipelined integrators, combs evaluated at the decimation tick
`timescale 1ns/1ns
`default_nettype none
`include "bac_defs.vh"

module bac_sinc4
#(
  parameter ACC_W = 56,
  parameter CNT_W = 13
)
(
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_clear,
  input  wire             i_stb,
  input  wire             i_bit,
  input  wire [CNT_W-1:0] i_ratio,
  input  wire [5:0]       i_shift,
  output reg              o_valid,
  output reg  [23:0]      o_data
);

  reg [ACC_W-1:0] integ     [0:3];
  reg [ACC_W-1:0] dly       [0:3];
  reg [ACC_W-1:0] comb      [0:3];
  reg [ACC_W-1:0] stage_in  [0:3];
  reg [CNT_W-1:0] cnt;
  integer         k;
  integer         m;

  // Modulator bit maps to +1 / -1
  wire [ACC_W-1:0] x = {{(ACC_W-1){~i_bit}}, 1'b1};
  wire dec_tick = i_stb && (cnt == i_ratio - {{(CNT_W-1){1'b0}}, 1'b1});

  function [23:0] clip;
    input [ACC_W-1:0] v;
    input [5:0]       s;
    reg   [ACC_W-1:0] t;
    begin
      t = $signed(v) >>> s;
      if (&t[ACC_W-1:23] || ~|t[ACC_W-1:23])
        clip = t[23:0];
      else if (t[ACC_W-1])
        clip = `BAC_NEG_FS;
      else
        clip = `BAC_POS_FS;
    end
  endfunction

  always @*
  begin
    stage_in[0] = integ[3];
    comb[0]     = integ[3] - dly[0];
    for (m = 1; m < 4; m = m + 1)
    begin
      stage_in[m] = comb[m-1];
      comb[m]     = comb[m-1] - dly[m];
    end
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        integ[k] <= {ACC_W{1'b0}};
        dly[k]   <= {ACC_W{1'b0}};
      end
      cnt     <= {CNT_W{1'b0}};
      o_valid <= 1'b0;
      o_data  <= 24'h000000;
    end
    else if (i_clear)
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        integ[k] <= {ACC_W{1'b0}};
        dly[k]   <= {ACC_W{1'b0}};
      end
      cnt     <= {CNT_W{1'b0}};
      o_valid <= 1'b0;
    end
    else
    begin
      o_valid <= dec_tick;
      if (i_stb)
      begin
        integ[0] <= integ[0] + x;
        for (k = 1; k < 4; k = k + 1)
          integ[k] <= integ[k] + integ[k-1];
        cnt <= dec_tick ? {CNT_W{1'b0}} : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (dec_tick)
      begin
        for (k = 0; k < 4; k = k + 1)
          dly[k] <= stage_in[k];
        o_data <= clip(comb[3], i_shift);
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/bac_top_checker.sv */
// Purpose: Port-level assertions for the conversion/output block
// Assumes: One clock domain, async active-low reset
// Notes:   Bound into bac_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
`include "bac_defs.vh"

module bac_top_checker
#(
  parameter [6:0]  MOD_DIV  = `BAC_MOD_DIV,
  parameter [12:0] DEC_FAST = `BAC_DEC_FAST
)
(
  input wire        I_REF_CLK,
  input wire        I_RST_N,
  input wire        I_SPEED,
  input wire        I_CHANNEL_SELECT_BIT0,
  input wire        I_CHANNEL_SELECT_BIT1,
  input wire        I_SCLK,
  input wire        O_READY_DATA_LINE,
  input wire        I_WB_CYC,
  input wire        I_WB_STB,
  input wire        I_WB_WE,
  input wire [7:0]  I_WB_ADR,
  input wire [31:0] O_WB_DAT,
  input wire        O_WB_ACK
);
  // Fast period is the shortest, so this bound holds at either rate
  localparam int SETTLE_MIN = 3 * MOD_DIV * DEC_FAST;
  logic [3:0]  since_sclk;
  logic [3:0]  since_chg;
  logic [31:0] settle_age;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      since_sclk <= 4'hF;
      since_chg  <= 4'hF;
      settle_age <= 32'hFFFFFFFF;
    end
    else
    begin
      since_sclk <= $rose(I_SCLK) ? 4'h0 : since_sclk + {3'h0, since_sclk != 4'hF};
      since_chg  <= ($changed(I_CHANNEL_SELECT_BIT0) || $changed(I_CHANNEL_SELECT_BIT1)
                    || $changed(I_SPEED) || (I_WB_CYC && I_WB_STB && I_WB_WE))
                    ? 4'h0 : since_chg + {3'h0, since_chg != 4'hF};
      settle_age <= ($changed(I_CHANNEL_SELECT_BIT0) || $changed(I_CHANNEL_SELECT_BIT1))
                    ? 32'h0 : settle_age + {31'h0, settle_age != 32'hFFFFFFFF};
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_req;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_ack_pulse;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  sequence s_chan_flip;
    $changed(I_CHANNEL_SELECT_BIT0) || $changed(I_CHANNEL_SELECT_BIT1);
  endsequence

  a_ack_one_pulse:
    assert property (s_req |=> s_ack_pulse) else $error("ack not a single pulse");
  a_ack_needs_req:
    assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB)) else $error("ack without request");
  a_unmapped_reads_zero:
    assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR >= 8'h10 |-> O_WB_DAT == 32'h0)
      else $error("unmapped read not zero");
  a_dat_only_read:
    assert property ($changed(O_WB_DAT) |-> $past(I_WB_CYC && I_WB_STB && !I_WB_WE))
      else $error("read data moved without read");
  a_reset_line_high:
    assert property ($rose(I_RST_N) |-> O_READY_DATA_LINE[*4]) else $error("line low after reset");
  a_chan_forces_high:
    assert property (s_chan_flip |-> ##[1:6] O_READY_DATA_LINE[*8])
      else $error("line not forced high on channel change");
  a_settle_holds_high:
    assert property (settle_age >= 32'h8 && settle_age < SETTLE_MIN |-> O_READY_DATA_LINE)
      else $error("line low during settling");
  a_rise_has_cause:
    assert property ($rose(O_READY_DATA_LINE) |-> since_sclk <= 4'h7 || since_chg <= 4'h8)
      else $error("line rose without shift clock or restart");
endmodule

bind bac_top bac_top_checker #(.MOD_DIV(MOD_DIV), .DEC_FAST(DEC_FAST)) bac_top_checker_i (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_SPEED(I_SPEED),
  .I_CHANNEL_SELECT_BIT0(I_CHANNEL_SELECT_BIT0), .I_CHANNEL_SELECT_BIT1(I_CHANNEL_SELECT_BIT1),
  .I_SCLK(I_SCLK), .O_READY_DATA_LINE(O_READY_DATA_LINE), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK));
`default_nettype wire

/* File: tb/bac_host.sv */
// Purpose: Host model polling the ready/data line and shifting words out
// Assumes: Tasks are entered at a rising edge of i_clk
// Notes:   Shift clock rests low between frames
`timescale 1ns/1ns
`default_nettype none

module bac_host
(
  input  wire logic i_clk,
  input  wire logic i_line,
  output var  logic o_sclk
);
  initial o_sclk = 1'b0;

  // One shift clock; half is both high and low time in clocks
  task automatic pulse(input int half);
    begin
      o_sclk <= 1'b1;
      repeat (half) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (half) @(posedge i_clk);
    end
  endtask

  // whole word done well inside one period
  task automatic read_word(input int half, output logic [23:0] w, output logic after);
    begin
      while (i_line !== 1'b0)
        @(posedge i_clk);
      // MSB first, one bit per rise
      for (int k = 23; k >= 0; k--)
      begin
        pulse(half);
        w[k] = i_line;
      end
      pulse(half);
      after = i_line;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/bac_top_tb.sv */
// Purpose: Self-checking bench for the conversion/output block
// Assumes: Short decimation ratios; host model on the serial side
// Notes:   Codes follow from constant or alternating bitstreams
`timescale 1ns/1ns
`default_nettype none
`include "bac_defs.vh"

module bac_top_tb;
  localparam int PF    = 512;
  localparam int PS    = 1024;
  localparam int LIMIT = 90000;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        mod_bit = 1'b0;
  logic        alt     = 1'b1;
  logic        speed   = 1'b1;
  logic        ch0     = 1'b0;
  logic        ch1     = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] dat_w   = 32'h0;
  logic [31:0] q;
  wire         line;
  wire         sclk;
  wire  [31:0] dat_r;
  wire         ack;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cyc_n       = 0;

  bac_top #(.MOD_DIV(7'h40), .DEC_SLOW(13'h0010), .DEC_FAST(13'h0008)) bac_top_i (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_MOD_BIT(mod_bit), .I_SPEED(speed),
    .I_CHANNEL_SELECT_BIT0(ch0), .I_CHANNEL_SELECT_BIT1(ch1), .I_SCLK(sclk),
    .O_READY_DATA_LINE(line), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat_w), .O_WB_DAT(dat_r), .O_WB_ACK(ack));
  bac_host bac_host_i (.i_clk(clk), .i_line(line), .o_sclk(sclk));

  initial
  begin
    forever #2 clk = ~clk;
  end

  // Alternating bits average to a zero input
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (alt)
      mod_bit <= cyc_n[6];
    if (cyc_n == LIMIT)
    begin
      miscompares++;
      end_sim;
    end
  end

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        miscompares++;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    begin
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      sel   <= s;
      dat_w <= d;
      @(posedge clk);
      while (ack !== 1'b1)
        @(posedge clk);
      r = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic t_regs;
    begin
      wb(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, q);
      wb(1'b0, 8'h10, 4'hF, 32'h0, q);
      chk_val("unmapped read", 32'h0, q);
      wb(1'b1, `BAC_REG_CTRL, 4'hE, 32'h3, q);
      wb(1'b0, `BAC_REG_CTRL, 4'hF, 32'h0, q);
      chk_val("ctrl without sel0", 32'h0, q);
      $display("t_regs done");
    end
  endtask

  task automatic t_settle(input logic which);
    int t0;
    begin
      if (which)
        ch1 <= ~ch1;
      else
        ch0 <= ~ch0;
      t0 = cyc_n;
      repeat (8) @(posedge clk);
      chk_val("line after toggle", 32'h1, {31'h0, line});
      repeat (3) bac_host_i.pulse(6);
      chk_val("line with sclk in settle", 32'h1, {31'h0, line});
      wb(1'b0, `BAC_REG_STATUS, 4'hF, 32'h0, q);
      chk_val("status in settle", 32'h3, {30'h0, q[2:1]});
      while (line !== 1'b0)
        @(posedge clk);
      chk_val("settle min", 32'h1, {31'h0, (cyc_n - t0) >= 3 * PF});
      chk_val("settle max", 32'h1, {31'h0, (cyc_n - t0) <= 5 * PF});
      $display("t_settle done");
    end
  endtask

  task automatic t_word(input logic a_mode, input logic mbit, input int half,
                        input logic [23:0] exp);
    logic [23:0] w;
    logic        hi;
    begin
      alt <= a_mode;
      // Let alt settle first, else the stream process races this write
      @(posedge clk);
      if (!a_mode)
        mod_bit <= mbit;
      repeat (6) bac_host_i.read_word(half, w, hi);
      bac_host_i.read_word(half, w, hi);
      chk_val("word", {8'h0, exp}, {8'h0, w});
      chk_val("line after 25th", 32'h1, {31'h0, hi});
      repeat (20) @(posedge clk);
      chk_val("line held high", 32'h1, {31'h0, line});
      wb(1'b0, `BAC_REG_RESULT, 4'hF, 32'h0, q);
      chk_val("result reg", {8'h0, exp}, q);
      $display("t_word done");
    end
  endtask

  task automatic t_rate(input int per);
    logic [31:0] c0;
    logic [31:0] c1;
    int          t0;
    begin
      repeat (8) @(posedge clk);
      while (line !== 1'b0)
        @(posedge clk);
      t0 = cyc_n;
      wb(1'b0, `BAC_REG_COUNT, 4'hF, 32'h0, c0);
      while (cyc_n < t0 + 8 * per)
        @(posedge clk);
      wb(1'b0, `BAC_REG_COUNT, 4'hF, 32'h0, c1);
      chk_val("results in window", 32'h8, c1 - c0);
      $display("t_rate done");
    end
  endtask

  task automatic t_override;
    begin
      wb(1'b1, `BAC_REG_CTRL, 4'hF, 32'h3, q);
      wb(1'b0, `BAC_REG_CTRL, 4'hF, 32'h0, q);
      chk_val("ctrl readback", 32'h3, q);
      $display("t_override done");
    end
  endtask

  task automatic end_sim;
    begin
      $display("Totals: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    while (line !== 1'b0)
      @(posedge clk);
    t_regs;
    t_settle(1'b0);
    t_settle(1'b1);
    t_word(1'b1, 1'b0, 6, 24'h000000);
    t_word(1'b0, 1'b0, 6, 24'hFFFFFF);
    t_rate(PF);
    speed <= 1'b0;
    t_rate(PS);
    t_override;
    t_rate(PF);
    wb(1'b1, `BAC_REG_CTRL, 4'hF, 32'h0, q);
    t_word(1'b1, 1'b0, 15, 24'h000000);
    end_sim;
  end
endmodule
`default_nettype wire
